// >>> rsc_map.svh
// Purpose: Offsets, reset values and timing counts of the reset source controller
// Assumes: 10 MHz core clock, 32-bit APB words, printed offsets used as word indices
// Notes: Definitions only
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// Word indices; byte address is four times the index
`define RSC_IDX_FLAGS 4'h0
`define RSC_IDX_SOFT 4'h1
`define RSC_IDX_GUARD 4'h2

`define RSC_FLAGS_W 6
`define RSC_FLAGS_POR_ONLY 6'h01
`define RSC_SOFT_RESET_VAL 8'h00
`define RSC_SOFT_TRIG_BIT 0

// Unlock key for the I/O register class; value is arbitrary
`define RSC_IO_KEY 8'hA5
`define RSC_GUARD_WRITES 3'h4

`define RSC_CLK_NS 100
`define RSC_INIT_NS 1000
`define RSC_INIT_CYC ((`RSC_INIT_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_STARTUP_UNIT_NS 1000000
`define RSC_STARTUP_UNIT_CYC ((`RSC_STARTUP_UNIT_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)

`endif

// >>> rsc_pkg.sv
// Purpose: Types of the reset source controller
// Assumes: Flag layout matches the cause flag register, bit 5 first
// Notes: Constants live in rsc_map.svh
package rsc_pkg;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SRC,
        ST_INIT,
        ST_CRC
    } rsc_state_e;

    // One bit per reset source, same order as the cause flags
    typedef struct packed {
        logic dbg;
        logic sw;
        logic wdt;
        logic ext;
        logic brownout_detector;
        logic por;
    } rsc_src_s;

    typedef struct packed {
        logic timer_override;
        logic bod_cfg;
        logic debug_if;
        logic volatile_logic;
    } rsc_clears_s;

endpackage

// >>> rsc_reset_source_controller.sv
// Contract
// - Controller always runs; brown-out and reset pin sources count only when their enable is set.
// - After a reset, cause flags show which source produced it.
// - After power-on reset only the power-on flag is set.
// - Flags stay until software writes one; writing zero changes nothing.
// - Every reset reloads all fuse-backed registers.
// - Power-on source is always enabled and resets while supply is low.
// - Brown-out resets below fuse level; unused detector forces minimum level.
// - Software trigger starts reset at once and holds through the whole sequence.
// - Enabled reset pin requests reset while low; release only when high.
// - Watchdog reset requests are accepted.
// - Each reset kind clears its own set of logic domains.
// - Reset is a source phase, then an init phase after all sources release.
// - Init phase is lengthened by the start-up delay fuse.
// - Init phase also waits for the boot memory CRC scan when enabled.
// - Controller works and accepts requests in active and all sleep modes.
// - Protected write is honoured only within four writes after the key.
// - Protected write without a correct unlock is ignored.
// - Soft reset register is guarded and needs the I/O register key.
// - Cause flags at index 0 bits 5..0; soft reset register at index 1.
// - Soft reset trigger reads zero; register resets to zero.
// - Power-on clears other flags; power-on flag cleared only by software.
//
// Purpose: Device reset controller with cause flags and guarded soft reset
// Assumes: rst_b is the power-on reset of this block; fuses are static levels
// Notes: APB slave, zero wait states, word index = paddr[5:2]
`timescale 1ns/1ps
`include "rsc_map.svh"

module rsc_reset_source_controller #(
    parameter int unsigned STARTUP_UNIT_CYC = `RSC_STARTUP_UNIT_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic por_active,
    input wire logic bod_below,
    input wire logic ext_reset_pin_b,
    input wire logic wdt_reset_req,
    input wire logic debug_reset_req,
    input wire logic reset_pin_fuse_field,
    input wire logic bod_enable_fuse,
    input wire logic [2:0] bod_level_fuse,
    input wire logic [2:0] startup_delay_fuse,
    input wire logic crc_scan_fuse,
    input wire logic crc_scan_done,
    output logic sys_reset_b,
    output logic fuse_reload,
    output logic [2:0] bod_level,
    output rsc_pkg::rsc_clears_s domain_clears
);

    localparam int NSYNC = 5;

    rsc_pkg::rsc_state_e state_r;
    rsc_pkg::rsc_state_e state_nxt;
    rsc_pkg::rsc_src_s src_live;
    logic [NSYNC-1:0] src_raw;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic [`RSC_FLAGS_W-1:0] flags_r;
    logic [`RSC_FLAGS_W-1:0] flags_nxt;
    logic [`RSC_FLAGS_W-1:0] flags_clr;
    logic [2:0] guard_cnt_r;
    logic [31:0] cnt_r;
    logic [31:0] init_len;
    logic hold_r;
    logic por_seen_r;
    logic bod_seen_r;
    logic any_src;
    logic async_src;
    logic sw_fire;
    logic wr_acc;
    logic setup;
    logic hit;
    logic acc;
    logic key_wr;
    logic [3:0] idx;

    // Bus decode
    assign idx = paddr[5:2];
    assign hit = (paddr[7:6] == 2'h0) && (idx <= `RSC_IDX_GUARD);
    assign setup = psel && !penable;
    assign acc = psel && penable;
    assign wr_acc = acc && pwrite && hit;
    // No wait states, so every access phase is also the last one
    assign pready = 1'b1;
    assign pslverr = acc && !hit;
    assign key_wr = wr_acc && (idx == `RSC_IDX_GUARD)
                    && (pwdata[7:0] == `RSC_IO_KEY);

    // Outside sources pass two flops before the state machine and flags look at them
    assign src_raw = {debug_reset_req, wdt_reset_req, !ext_reset_pin_b,
                      bod_below, por_active};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (!rst_b) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= src_raw[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    // Guarded trigger; only a write inside the unlock window fires
    assign sw_fire = wr_acc && (idx == `RSC_IDX_SOFT) && (guard_cnt_r != 3'h0)
                     && pwdata[`RSC_SOFT_TRIG_BIT];

    always_comb begin
        src_live.por = sync2_r[0];
        src_live.brownout_detector = sync2_r[1] && bod_enable_fuse;
        src_live.ext = sync2_r[2] && reset_pin_fuse_field;
        src_live.wdt = sync2_r[3];
        // Debug request comes only from the debugger port
        src_live.sw = sw_fire;
        src_live.dbg = sync2_r[4];
    end

    assign any_src = |src_live;

    // Raw path so reset asserts without waiting for a clock edge
    // Trade-off: a short glitch on a raw source can pulse this output
    assign async_src = por_active || (bod_below && bod_enable_fuse)
                       || (!ext_reset_pin_b && reset_pin_fuse_field)
                       || wdt_reset_req || debug_reset_req || sw_fire;
    assign sys_reset_b = !(hold_r || async_src);

    assign init_len = 32'(`RSC_INIT_CYC)
                      + 32'(startup_delay_fuse) * STARTUP_UNIT_CYC;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            rsc_pkg::ST_RUN: begin
                if (any_src) begin
                    state_nxt = rsc_pkg::ST_SRC;
                end
            end
            rsc_pkg::ST_SRC: begin
                if (!any_src) begin
                    state_nxt = rsc_pkg::ST_INIT;
                end
            end
            rsc_pkg::ST_INIT: begin
                if (any_src) begin
                    state_nxt = rsc_pkg::ST_SRC;
                end else if (cnt_r == 32'h1) begin
                    state_nxt = crc_scan_fuse ? rsc_pkg::ST_CRC : rsc_pkg::ST_RUN;
                end
            end
            rsc_pkg::ST_CRC: begin
                if (any_src) begin
                    state_nxt = rsc_pkg::ST_SRC;
                end else if (crc_scan_done) begin
                    state_nxt = rsc_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = rsc_pkg::ST_SRC;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r <= rsc_pkg::ST_SRC;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Release is synchronous: hold follows the next state
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            hold_r <= 1'b1;
        end else begin
            hold_r <= (state_nxt != rsc_pkg::ST_RUN);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cnt_r <= 32'h1;
        end else if (state_r != rsc_pkg::ST_INIT) begin
            cnt_r <= init_len;
        end else if (cnt_r != 32'h1) begin
            cnt_r <= cnt_r - 32'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            fuse_reload <= 1'b0;
        end else begin
            fuse_reload <= (state_r == rsc_pkg::ST_SRC)
                           && (state_nxt == rsc_pkg::ST_INIT);
        end
    end

    // Remember the reset kind until the sequence ends
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            por_seen_r <= 1'b1;
        end else if (state_nxt == rsc_pkg::ST_RUN) begin
            por_seen_r <= 1'b0;
        end else if (src_live.por) begin
            por_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bod_seen_r <= 1'b0;
        end else if (state_nxt == rsc_pkg::ST_RUN) begin
            bod_seen_r <= 1'b0;
        end else if (src_live.brownout_detector) begin
            bod_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            domain_clears <= '1;
        end else begin
            domain_clears.timer_override <= !sys_reset_b && por_seen_r;
            domain_clears.bod_cfg <= !sys_reset_b && por_seen_r;
            domain_clears.debug_if <= !sys_reset_b
                                      && (por_seen_r || bod_seen_r);
            domain_clears.volatile_logic <= !sys_reset_b;
        end
    end

    // An unused detector is held at its lowest trigger level
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bod_level <= 3'h0;
        end else begin
            bod_level <= bod_enable_fuse ? bod_level_fuse : 3'h0;
        end
    end

    // Key opens a window of four bus writes, the key write excluded
    always_ff @(posedge core_clk) begin
        if (!rst_b || hold_r) begin
            guard_cnt_r <= 3'h0;
        end else if (key_wr) begin
            guard_cnt_r <= `RSC_GUARD_WRITES;
        end else if (acc && pwrite && (guard_cnt_r != 3'h0)) begin
            guard_cnt_r <= guard_cnt_r - 3'h1;
        end
    end

    // Flags: set wins over a software clear in the same cycle
    assign flags_clr = (wr_acc && (idx == `RSC_IDX_FLAGS))
                       ? pwdata[`RSC_FLAGS_W-1:0] : '0;

    always_comb begin
        if (src_live.por || por_seen_r) begin
            // Other causes stay hidden until a full boot after power-on
            flags_nxt = `RSC_FLAGS_POR_ONLY;
        end else begin
            flags_nxt = (flags_r & ~flags_clr) | src_live;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flags_r <= `RSC_FLAGS_POR_ONLY;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Read data is captured in the setup cycle, valid during access
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prdata <= 32'h0;
        end else if (setup && !pwrite && hit) begin
            case (idx)
                `RSC_IDX_FLAGS: begin
                    prdata <= {26'h0, flags_r};
                end
                `RSC_IDX_SOFT: begin
                    prdata <= {24'h0, `RSC_SOFT_RESET_VAL};
                end
                `RSC_IDX_GUARD: begin
                    prdata <= {29'h0, guard_cnt_r};
                end
                default: begin
                    prdata <= 32'h0;
                end
            endcase
        end else if (setup) begin
            prdata <= 32'h0;
        end
    end

endmodule

// >>> rsc_props.sv
// Purpose: Concurrent checks on the reset source controller ports
// Assumes: STARTUP_UNIT_CYC matches the design instance
// Notes: Attached by the bind after the module
`timescale 1ns/1ps
`include "rsc_map.svh"
module rsc_props #(
    parameter int unsigned STARTUP_UNIT_CYC = 4
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic por_active,
    input wire logic ext_reset_pin_b,
    input wire logic wdt_reset_req,
    input wire logic reset_pin_fuse_field,
    input wire logic bod_enable_fuse,
    input wire logic [2:0] bod_level_fuse,
    input wire logic [2:0] startup_delay_fuse,
    input wire logic crc_scan_fuse,
    input wire logic crc_scan_done,
    input wire logic sys_reset_b,
    input wire logic fuse_reload,
    input wire logic [2:0] bod_level,
    input wire rsc_pkg::rsc_clears_s domain_clears
);
    logic [15:0] init_cnt_r;
    logic reload_seen_r;
    int unsigned init_min;
    assign init_min = `RSC_INIT_CYC + startup_delay_fuse * STARTUP_UNIT_CYC;
    // Set by each reload, dropped once reset has been released
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reload_seen_r <= 1'b0;
        end else if (fuse_reload) begin
            reload_seen_r <= 1'b1;
        end else if (sys_reset_b) begin
            reload_seen_r <= 1'b0;
        end
    end
    // Saturates so a long run never wraps into a false short count
    always_ff @(posedge core_clk) begin
        if (fuse_reload) begin
            init_cnt_r <= 16'h0001;
        end else if (init_cnt_r != 16'hFFFF) begin
            init_cnt_r <= init_cnt_r + 16'h0001;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    chk_err_unmapped:
    assert property (psel && penable && (paddr[5:2] > 4'h2 || paddr[7:6] != 2'h0)
        |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    chk_soft_reads_zero:
    assert property (psel && penable && !pwrite && paddr == 8'h04 |-> prdata == 32'h0)
        else $error("soft reset register not zero");
    chk_flag_width:
    assert property (psel && penable && !pwrite && paddr == 8'h00 |-> prdata[31:6] == 26'h0)
        else $error("flag register upper bits set");
    chk_por_holds:
    assert property (por_active |-> !sys_reset_b) else $error("reset free during power-on");
    chk_pin_holds:
    assert property (reset_pin_fuse_field && !ext_reset_pin_b |-> !sys_reset_b)
        else $error("reset free while pin low");
    chk_wdt_holds:
    assert property (wdt_reset_req |-> !sys_reset_b) else $error("watchdog request ignored");
    chk_reload_pulse:
    assert property (fuse_reload |-> !sys_reset_b ##1 !fuse_reload)
        else $error("fuse reload not a pulse in reset");
    chk_clear_volatile:
    assert property ($fell(sys_reset_b) |=> domain_clears.volatile_logic)
        else $error("volatile logic not cleared");
    chk_por_superset:
    assert property (domain_clears.timer_override |-> domain_clears.bod_cfg
        && domain_clears.debug_if && domain_clears.volatile_logic)
        else $error("power-on clears incomplete");
    chk_init_length:
    assert property ($rose(sys_reset_b) && !crc_scan_fuse |-> int'(init_cnt_r) >= init_min - 1
        && int'(init_cnt_r) <= init_min + 2) else $error("init phase length wrong");
    chk_crc_waits:
    assert property ($rose(sys_reset_b) && crc_scan_fuse |-> $past(crc_scan_done))
        else $error("released before scan done");
    chk_bod_level:
    assert property ($past(rst_b) && $stable(bod_enable_fuse) && $stable(bod_level_fuse)
        |-> bod_level == (bod_enable_fuse ? bod_level_fuse : 3'h0))
        else $error("brown-out level wrong");
    chk_reload_each_boot:
    assert property ($rose(sys_reset_b) |-> reload_seen_r)
        else $error("reset released without fuse reload");
endmodule

bind rsc_reset_source_controller rsc_props #(.STARTUP_UNIT_CYC(STARTUP_UNIT_CYC)) u_props (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .por_active(por_active),
    .ext_reset_pin_b(ext_reset_pin_b), .wdt_reset_req(wdt_reset_req),
    .reset_pin_fuse_field(reset_pin_fuse_field), .bod_enable_fuse(bod_enable_fuse),
    .bod_level_fuse(bod_level_fuse), .startup_delay_fuse(startup_delay_fuse),
    .crc_scan_fuse(crc_scan_fuse), .crc_scan_done(crc_scan_done),
    .sys_reset_b(sys_reset_b), .fuse_reload(fuse_reload), .bod_level(bod_level),
    .domain_clears(domain_clears));

// >>> rsc_src_model.sv
// Purpose: Reset sources and boot scan seen by the controller
// Assumes: src_on bits are {dbg, wdt, ext, bod, por}
// Notes: Levels follow the bench; scan time set by CRC_CYC
`timescale 1ns/1ps
module rsc_src_model #(
    parameter int unsigned CRC_CYC = 30
) (
    input wire logic core_clk,
    input wire logic [4:0] src_on,
    input wire logic fuse_reload,
    output logic por_active,
    output logic bod_below,
    output logic ext_reset_pin_b,
    output logic wdt_reset_req,
    output logic debug_reset_req,
    output logic crc_scan_done
);
    logic [7:0] crc_cnt_r = 8'h00;
    assign por_active = src_on[0];
    assign bod_below = src_on[1];
    assign ext_reset_pin_b = ~src_on[2];
    assign wdt_reset_req = src_on[3];
    // Raised only by the bench acting as external debugger
    assign debug_reset_req = src_on[4];
    // Scan restarts on each reload, so every boot waits a full pass
    always_ff @(posedge core_clk) begin
        if (fuse_reload) begin
            crc_cnt_r <= 8'h00;
        end else if (crc_cnt_r != 8'hFF) begin
            crc_cnt_r <= crc_cnt_r + 8'h01;
        end
    end
    assign crc_scan_done = (32'(crc_cnt_r) >= CRC_CYC);
endmodule

// >>> tb_top.sv
// Purpose: Register and reset-source tests of the reset source controller
// Assumes: Zero wait state APB, start-up unit shortened to 4 cycles
// Notes: Sources are driven through the partner model
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [4:0] src_on = 5'h00;
    logic pin_f = 1'b1;
    logic bod_en = 1'b1;
    logic crc_f = 1'b1;
    logic [2:0] sut_f = 3'h2;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, por_a, bod_b, pin_b, wdt_r, dbg_r, crc_d;
    logic sys_reset_b, fuse_reload;
    logic [2:0] bod_level;
    rsc_pkg::rsc_clears_s clears;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;

    always #50 core_clk = ~core_clk;

    rsc_reset_source_controller #(.STARTUP_UNIT_CYC(4)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_active(por_a),
        .bod_below(bod_b), .ext_reset_pin_b(pin_b), .wdt_reset_req(wdt_r),
        .debug_reset_req(dbg_r), .reset_pin_fuse_field(pin_f), .bod_enable_fuse(bod_en),
        .bod_level_fuse(3'h5), .startup_delay_fuse(sut_f), .crc_scan_fuse(crc_f),
        .crc_scan_done(crc_d), .sys_reset_b(sys_reset_b), .fuse_reload(fuse_reload),
        .bod_level(bod_level), .domain_clears(clears));
    rsc_src_model model (.core_clk(core_clk), .src_on(src_on), .fuse_reload(fuse_reload),
        .por_active(por_a), .bod_below(bod_b), .ext_reset_pin_b(pin_b),
        .wdt_reset_req(wdt_r), .debug_reset_req(dbg_r), .crc_scan_done(crc_d));

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // A slave that never answers is ended by the bench timeout
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // Samples on the falling edge so register updates have landed
    task automatic sample(input logic [31:0] got, input logic [31:0] exp);
        @(negedge core_clk);
        check(got, exp);
        @(posedge core_clk);
    endtask

    task automatic wait_up;
        int n;
        n = 0;
        while (sys_reset_b !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        check(32'(sys_reset_b), 32'h1);
        @(posedge core_clk);
    endtask

    task automatic hold_src(input logic [4:0] s);
        src_on <= s;
        repeat (6) @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        wait_up();
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        check(32'(err), 32'h1);
        apb(1'b1, 8'h00, 32'h3E);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, 8'h04, 32'h1);
        sample(32'(sys_reset_b), 32'h1);
        // Window of four writes: the fifth write after the key is refused
        for (int k = 4; k >= 3; k--) begin
            apb(1'b1, 8'h08, 32'hA5);
            repeat (k) apb(1'b1, 8'h00, 32'h0);
            apb(1'b1, 8'h04, 32'h1);
            sample(32'(sys_reset_b), (k == 4) ? 32'h1 : 32'h0);
        end
        wait_up();
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h10);
        apb(1'b1, 8'h00, 32'h3F);
        crc_f <= 1'b0;
        sample(32'(bod_level), 32'h5);
        for (int i = 1; i < 5; i++) begin
            hold_src(5'(1 << i));
            sample(32'(clears), (i == 1) ? 32'h3 : 32'h1);
            src_on <= 5'h00;
            wait_up();
            apb(1'b0, 8'h00, 32'h0);
            check(rd, (i == 4) ? 32'h20 : 32'h1 << i);
            apb(1'b1, 8'h00, 32'h3F);
        end
        pin_f <= 1'b0;
        hold_src(5'h04);
        sample(32'(sys_reset_b), 32'h1);
        pin_f <= 1'b1;
        hold_src(5'h0C);
        src_on <= 5'h00;
        wait_up();
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0C);
        sut_f <= 3'h0;
        hold_src(5'h01);
        sample(32'(clears), 32'hF);
        src_on <= 5'h00;
        wait_up();
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h1);
        bod_en <= 1'b0;
        repeat (3) @(posedge core_clk);
        sample(32'(bod_level), 32'h0);
        final_report();
    end
endmodule
